// ### checksum_defines.svh
// Register offsets, field positions and reset values of the checksum accelerator.
// Assumes a 32-bit host word port and a 32-bit pipelined memory read port.
`ifndef CHECKSUM_DEFINES_SVH
`define CHECKSUM_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CK_OFS_STATUS   5'h00
`define CK_OFS_ADDR     5'h04
`define CK_OFS_LENGTH   5'h0c
`define CK_OFS_CONTROL  5'h18
`define CK_OFS_RESULT   5'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CK_ST_DONE      0
`define CK_ST_BUSY      1
`define CK_CTL_START    0
`define CK_CTL_IRQ_EN   1

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define CK_ZERO32       32'h0000_0000
`define CK_ZERO16       16'h0000
`define CK_MAX_OUTSTAND 5'h10

`endif

// ### checksum_pkg.sv
// Types shared by the checksum accelerator.
// Assumes nothing of its surroundings.
package checksum_pkg;
  typedef enum logic [1:0] {IDLE, RUN, FOLD} ck_state_t;
endpackage

// ### checksum_accel.sv
// Checksum accelerator: host register port, pipelined read port and
// end-around-carry accumulator. Assumes memory answers reads in order.
`timescale 1ns/1ps
`default_nettype none
`include "checksum_defines.svh"

// Functional notes
// R1 - Carry out folds back into next addition
// R2 - Read requests issue without waiting for data
// R3 - One returned word accumulated every clock
// R4 - Host programs address, length, control
// R5 - Checksum result readable at own offset
// R6 - Status and control are separate registers
// R7 - Interrupt raised when whole buffer summed
// R8 - Status write of one to done clears pending interrupt
// R9 - Result is 16 bits, upper zero
// R10 - Status done bit is write one to clear
// R11 - Start bit begins; busy/done reported
module checksum_accel (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Host register port
  input  wire logic [4:0]  host_addr,
  input  wire logic        host_write,
  input  wire logic        host_read,
  input  wire logic [31:0] host_wdata,
  output logic      [31:0] host_rdata,
  // Memory read port
  output logic      [31:0] mem_addr,
  output logic             mem_read,
  input  wire logic        mem_waitrequest,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_rdata_valid,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // State and working registers
  // ----------------------------------------------------------------
  checksum_pkg::ck_state_t state_r;
  logic [31:0] base_r;
  logic [30:0] length_r;
  logic [1:0]  control_r;
  logic        done_r;
  logic [31:0] rd_addr_r;
  logic [29:0] req_left_r;
  logic [29:0] rsp_left_r;
  logic [4:0]  outstand_r;
  logic [31:0] acc_r;
  logic        carry_r;
  logic [15:0] result_r;
  logic [32:0] sum_nxt;
  logic [16:0] fold_nxt;
  logic        req_go;
  logic        wr_status;
  logic        wr_control;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Offset match shared by every write strobe
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Words to fetch: a partial trailing word costs a whole read and its
  // spare bytes are summed unmasked, so hosts should pad with zeros
  function automatic logic [29:0] word_count(input logic [30:0] len);
    word_count = {1'b0, len[30:2]} + {29'h0000_0000, |len[1:0]};
  endfunction

  assign wr_status  = host_write && hit(host_addr, `CK_OFS_STATUS);
  assign wr_control = host_write && hit(host_addr, `CK_OFS_CONTROL);

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      base_r    <= `CK_ZERO32;
      length_r  <= 31'h0000_0000;
    end else if (state_r == checksum_pkg::IDLE && host_write) begin
      // Address and length are frozen while a buffer is in flight
      // Low two address bits are dropped so every fetch is word-aligned
      if (hit(host_addr, `CK_OFS_ADDR))
        base_r <= {host_wdata[31:2], 2'b00}; // R4
      if (hit(host_addr, `CK_OFS_LENGTH))
        length_r <= host_wdata[30:0]; // R4
    end
  end

  // Start drops once the run is under way, so a later read shows it clear
  always_ff @(posedge clk) begin
    if (rst) begin
      control_r <= 2'b00;
    end else if (wr_control) begin
      control_r <= host_wdata[1:0]; // R6
    end else if (state_r != checksum_pkg::IDLE) begin
      control_r[`CK_CTL_START] <= 1'b0;
    end
  end

  // Done: set wins over a clearing write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (state_r == checksum_pkg::FOLD) begin
      done_r <= 1'b1; // R7
    end else if (wr_status && host_wdata[`CK_ST_DONE]) begin
      done_r <= 1'b0; // R8 R10
    end
  end

  // Registered read data stands until the next read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata <= `CK_ZERO32;
    end else if (host_read) begin
      unique case (host_addr)
        `CK_OFS_STATUS:
          host_rdata <= {30'h0000_0000, state_r != checksum_pkg::IDLE, done_r}; // R11
        `CK_OFS_ADDR:    host_rdata <= base_r;
        `CK_OFS_LENGTH:  host_rdata <= {1'b0, length_r};
        `CK_OFS_CONTROL: host_rdata <= {30'h0000_0000, control_r};
        `CK_OFS_RESULT:  host_rdata <= {`CK_ZERO16, result_r}; // R5 R9
        default:         host_rdata <= `CK_ZERO32;
      endcase
    end
  end

  // Dropping the enable hides a pending interrupt but does not clear it
  assign irq = done_r && control_r[`CK_CTL_IRQ_EN]; // R7

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= checksum_pkg::IDLE;
    end else begin
      unique case (state_r)
        checksum_pkg::IDLE:
          if (control_r[`CK_CTL_START] && !done_r)
            state_r <= checksum_pkg::RUN; // R11
        checksum_pkg::RUN:
          if (rsp_left_r == 30'h0000_0000)
            state_r <= checksum_pkg::FOLD;
        checksum_pkg::FOLD:
          state_r <= checksum_pkg::IDLE;
        // The spare code falls back to idle instead of locking up
        default: state_r <= checksum_pkg::IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pipelined read requests
  // ----------------------------------------------------------------
  // Outstanding count is capped so an in-order memory can never overrun us
  assign req_go   = state_r == checksum_pkg::RUN && req_left_r != 30'h0000_0000
                    && outstand_r != `CK_MAX_OUTSTAND;
  assign mem_read = req_go; // R2
  assign mem_addr = rd_addr_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_addr_r  <= `CK_ZERO32;
      req_left_r <= 30'h0000_0000;
    end else if (state_r == checksum_pkg::IDLE) begin
      rd_addr_r  <= base_r;
      // Partial trailing word rounds up to a whole word
      req_left_r <= word_count(length_r);
    end else if (req_go && !mem_waitrequest) begin
      rd_addr_r  <= rd_addr_r + 32'h0000_0004; // R2
      req_left_r <= req_left_r - 30'h0000_0001;
    end
  end

  // Accepted requests minus returned words
  always_ff @(posedge clk) begin
    if (rst) begin
      outstand_r <= 5'h00;
    end else begin
      outstand_r <= outstand_r + {4'h0, req_go && !mem_waitrequest}
                    - {4'h0, mem_rdata_valid};
    end
  end

  // ----------------------------------------------------------------
  // End-around-carry accumulator
  // ----------------------------------------------------------------
  // Carry is held one word and added with the next, keeping the adder 33 bits
  assign sum_nxt  = {1'b0, acc_r} + {1'b0, mem_rdata} + {32'h0000_0000, carry_r}; // R1
  assign fold_nxt = {1'b0, acc_r[31:16]} + {1'b0, acc_r[15:0]} + {16'h0000, carry_r};

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r      <= `CK_ZERO32;
      carry_r    <= 1'b0;
      rsp_left_r <= 30'h0000_0000;
    end else if (state_r == checksum_pkg::IDLE) begin
      acc_r      <= `CK_ZERO32;
      carry_r    <= 1'b0;
      rsp_left_r <= word_count(length_r);
    end else if (state_r == checksum_pkg::RUN && mem_rdata_valid) begin
      acc_r      <= sum_nxt[31:0]; // R3
      carry_r    <= sum_nxt[32]; // R1
      rsp_left_r <= rsp_left_r - 30'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_r <= `CK_ZERO16;
    end else if (state_r == checksum_pkg::FOLD) begin
      // Second end-around step, then complement as a receiver compares it
      result_r <= ~(fold_nxt[15:0] + {15'h0000, fold_nxt[16]}); // R9
    end
  end

endmodule
`default_nettype wire

// ### checksum_accel_sva.sv
// Port checker for the checksum accelerator.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module checksum_accel_sva (
  // Watched ports
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [4:0]  host_addr,
  input wire logic        host_write,
  input wire logic        host_read,
  input wire logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_read,
  input wire logic        mem_waitrequest,
  input wire logic        mem_rdata_valid,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  upper_zero_a: assert property (host_read && host_addr == 5'h1c |=> !host_rdata[31:16])
    else $error("result upper half set");
  hole_zero_a: assert property (host_read && host_addr == 5'h08 |=> host_rdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!host_read |=> $stable(host_rdata))
    else $error("read data moved");
  req_hold_a: assert property (mem_read && mem_waitrequest |=> mem_read && $stable(mem_addr))
    else $error("stalled request dropped");
  addr_step_a: assert property (mem_read && !mem_waitrequest ##1 mem_read |->
    mem_addr == $past(mem_addr) + 32'h4)
    else $error("address step wrong");
  irq_clear_a: assert property (irq && host_write && host_addr == 5'h00 && host_wdata[0] |=> !irq)
    else $error("irq not cleared");
  done_seen_a: assert property (irq && host_read && host_addr == 5'h00 |=> host_rdata[0])
    else $error("done not shown");
  busy_seen_a: assert property (mem_read && host_read && host_addr == 5'h00 |=> host_rdata[1])
    else $error("busy not shown");
  done_quiet_a: assert property (irq |-> !mem_read)
    else $error("fetch after done");
  cover property (irq);
  cover property (mem_read && mem_waitrequest);
  cover property (mem_rdata_valid ##1 mem_rdata_valid);
endmodule
bind checksum_accel checksum_accel_sva checksum_accel_sva_i (.clk, .rst, .host_addr,
  .host_write, .host_read, .host_wdata, .host_rdata, .mem_addr, .mem_read, .mem_waitrequest,
  .mem_rdata_valid, .irq);
`default_nettype wire

// ### mem_model.sv
// Buffer memory answering in order two cycles after acceptance.
// Assumes word addresses; slow stalls every other cycle.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock, reset and pacing
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  // Read port
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_read,
  output logic             mem_waitrequest,
  output logic      [31:0] mem_rdata,
  output logic             mem_rdata_valid
);
  logic [1:0]  vld_r;
  logic [31:0] d0_r;
  logic [31:0] d1_r;
  logic        tgl_r;
  assign mem_waitrequest = slow & tgl_r;
  always_ff @(posedge clk) begin
    tgl_r <= rst ? 1'b0 : ~tgl_r;
    vld_r <= rst ? 2'b00 : {vld_r[0], mem_read & ~mem_waitrequest};
    d0_r  <= mem_addr * 32'h9e37_79b1;
    d1_r  <= d0_r;
  end
  // Idle bus shows the inverse so a stale word never passes for data
  assign mem_rdata       = vld_r[1] ? d1_r : ~d1_r;
  assign mem_rdata_valid = vld_r[1];
endmodule
`default_nettype wire

// ### buffer_checksum_accelerator_test.sv
// Self-checking bench for the checksum accelerator.
// Assumes mem_model as the buffer memory.
`timescale 1ns/1ps
`default_nettype none
module buffer_checksum_accelerator_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  logic [4:0]  host_addr = 5'h00;
  logic        host_write = 1'b0;
  logic        host_read = 1'b0;
  logic [31:0] host_wdata = 32'h0;
  wire logic [31:0] host_rdata, mem_addr, mem_rdata;
  wire logic        mem_read, mem_waitrequest, mem_rdata_valid, irq;
  int          miscompares = 0;
  int          total_checks = 0;
  always #5 clk = ~clk;
  checksum_accel checksum_accel_i (.clk, .rst, .host_addr, .host_write, .host_read, .host_wdata,
    .host_rdata, .mem_addr, .mem_read, .mem_waitrequest, .mem_rdata, .mem_rdata_valid, .irq);
  mem_model mem_model_i (.clk, .rst, .slow, .mem_addr, .mem_read, .mem_waitrequest,
    .mem_rdata, .mem_rdata_valid);
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    host_addr  <= a;
    host_wdata <= d;
    host_write <= 1'b1;
    @(posedge clk);
    host_write <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [4:0] a, output logic [31:0] v);
    @(posedge clk);
    host_addr <= a;
    host_read <= 1'b1;
    @(posedge clk);
    host_read <= 1'b0;
    @(negedge clk);
    v = host_rdata;
  endtask
  // Ones-complement sum folds to the same value as end-around carry
  function automatic logic [15:0] ck(logic [31:0] base, logic [31:0] len);
    logic [47:0] s;
    s = 48'h0;
    for (logic [31:0] a = base; a < base + len; a += 32'h4) s += 32'(a * 32'h9e37_79b1);
    while (s[47:16] != 32'h0) s = s[15:0] + s[47:16];
    return ~s[15:0];
  endfunction
  task automatic regs();
    logic [31:0] v;
    rd(5'h08, v);
    chk("hole", v, 32'h0);
    wr(5'h04, 32'h0000_0013);
    rd(5'h04, v);
    chk("base", v, 32'h0000_0010);
  endtask
  task automatic run(logic [31:0] base, logic [31:0] len, logic pace);
    logic [31:0] v;
    int          n;
    @(posedge clk);
    slow <= pace;
    wr(5'h04, base);
    wr(5'h0c, len);
    wr(5'h18, 32'h3);
    rd(5'h00, v);
    if (len > 32'h20) chk("busy", v & 32'h3, 32'h2);
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("irq", irq, 1'b1);
    if (irq !== 1'b1) conclude();
    if (!pace) chk("pace", 32'(n < len / 4 + 12), 32'h1);
    wr(5'h00, 32'h0);
    chk("irq kept", irq, 1'b1);
    rd(5'h00, v);
    chk("done kept", v, 32'h1);
    rd(5'h1c, v);
    chk("result", v, {16'h0, ck(base, len)});
    wr(5'h00, 32'h1);
    chk("irq clear", irq, 1'b0);
    rd(5'h00, v);
    chk("status", v, 32'h0);
  endtask
  // Interrupt masked: host polls status, address writes while busy are ignored
  task automatic quiet_run();
    logic [31:0] v;
    int          n;
    wr(5'h04, 32'h0000_5000);
    wr(5'h0c, 32'h40);
    wr(5'h18, 32'h1);
    wr(5'h04, 32'h0000_6000);
    rd(5'h04, v);
    chk("base frozen", v, 32'h0000_5000);
    rd(5'h18, v);
    chk("start cleared", v, 32'h0);
    v = 32'h0;
    n = 0;
    while (v[0] !== 1'b1 && n < 100) begin
      rd(5'h00, v);
      n++;
    end
    chk("done polled", v, 32'h1);
    if (v[0] !== 1'b1) conclude();
    chk("irq masked", {31'h0000_0000, irq}, 32'h0);
    rd(5'h1c, v);
    chk("quiet result", v, {16'h0, ck(32'h0000_5000, 32'h40)});
    wr(5'h00, 32'h1);
    rd(5'h00, v);
    chk("quiet status", v, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    regs();
    run(32'h0000_1000, 32'h40, 1'b0);
    run(32'h0000_2000, 32'h24, 1'b1);
    run(32'h0000_3000, 32'h6, 1'b0);
    run(32'h0000_0400, 32'h0, 1'b0);
    quiet_run();
    conclude();
  end
endmodule
`default_nettype wire
